// *** rtl/addr_stack_pkg.sv ***
`default_nettype none
package addr_stack_pkg;
   // Bus and stack geometry
   localparam int          DATA_W      = 8;
   localparam int          STACK_DEPTH = 4;
   localparam int          IDX_W       = 2;
   // History locations in the extended bank
   localparam logic [7:0]  ADDR_HIST_TWO   = 8'h4e;
   localparam logic [7:0]  ADDR_HIST_OTHER = 8'h4f;
   // Control register A, holds the bank select bit
   localparam logic [7:0]  ADDR_CTRL_A     = 8'h0a;
   // Stack slot read back at each history location
   localparam logic [1:0]  SLOT_TWO        = 2'h2;
   localparam logic [1:0]  SLOT_OTHER      = 2'h3;
   // Idle pattern on the data bus
   localparam logic [7:0]  DATA_IDLE       = 8'h00;
endpackage : addr_stack_pkg
`default_nettype wire

// *** rtl/address_latch_recovery_stack.sv ***
// Notes on behaviour
// RULE1 - Address latched on strobe fall, used after
// RULE2 - Each latch pushes history, older entries shift
// RULE3 - Four entries: current plus three older
// RULE4 - History readable at two extended-bank locations
// RULE5 - Host accesses 0Ah first, pushing lost address
// RULE6 - 4Eh returns address two strobes earlier
// RULE7 - Firmware reissues recovered address, then resumes
// RULE8 - Reads never alter stack; history read-only
`default_nettype none
module address_latch_recovery_stack
   import addr_stack_pkg::*;
(
   // Clock and reset
   input  wire logic              mclk,
   input  wire logic              reset_n,
   // Multiplexed host bus pins
   input  wire logic              addr_strobe,
   input  wire logic              chip_sel_n,
   input  wire logic              rd_n,
   input  wire logic [DATA_W-1:0] ad_in,
   output logic      [DATA_W-1:0] ad_out,
   output logic                   ad_oe_n,
   // Latched address of the current access
   output logic      [DATA_W-1:0] cur_addr
);

   // Reset release synchroniser
   logic       rst_s1;                  // First stage, read only by second
   logic       rst_n_i;                 // Released reset for the block

   // Assert at once, release two edges later so every flop reset by rst_n_i leaves reset together
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         rst_s1  <= 1'b0;
         rst_n_i <= 1'b0;
      end else begin
         rst_s1  <= 1'b1;
         rst_n_i <= rst_s1;
      end
   end

   // Pin synchronisers: three stages, change counts when 2 and 3 agree
   logic [2:0] ale_sy;                  // Strobe sync chain
   logic [2:0] cs_sy;                   // Chip select sync chain
   logic [2:0] rd_sy;                   // Read strobe sync chain
   logic       ale_q;                   // Filtered strobe level
   logic       cs_q;                    // Filtered chip select, active low
   logic       rd_q;                    // Filtered read strobe, active low
   logic       next_ale_q;
   logic       next_cs_q;
   logic       next_rd_q;

   // Filter: accept a level only once the two late stages agree
   always_comb begin
      next_ale_q = (ale_sy[1] == ale_sy[2]) ? ale_sy[2] : ale_q;
      next_cs_q  = (cs_sy[1] == cs_sy[2]) ? cs_sy[2] : cs_q;
      next_rd_q  = (rd_sy[1] == rd_sy[2]) ? rd_sy[2] : rd_q;
   end

   // Chains reset to the idle pin levels, so no false edge follows reset:
   // the strobe idles low, chip select and read idle high
   always_ff @(posedge mclk or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ale_sy <= 3'h0;
         cs_sy  <= 3'h7;
         rd_sy  <= 3'h7;
         ale_q  <= 1'b0;
         cs_q   <= 1'b1;
         rd_q   <= 1'b1;
      end else begin
         ale_sy <= {ale_sy[1:0], addr_strobe};
         cs_sy  <= {cs_sy[1:0], chip_sel_n};
         rd_sy  <= {rd_sy[1:0], rd_n};
         ale_q  <= next_ale_q;
         cs_q   <= next_cs_q;
         rd_q   <= next_rd_q;
      end
   end

   // Address bus sampled alongside the strobe so it stays aligned.
   // Address must hold across the fall, so a 3-deep delay is safe.
   logic [DATA_W-1:0] ad_d1;            // Bus, stage one
   logic [DATA_W-1:0] ad_d2;            // Bus, stage two
   logic [DATA_W-1:0] ad_d3;            // Bus, stage three
   // No agreement filter here: the host keeps the bus steady around the fall
   always_ff @(posedge mclk or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ad_d1 <= DATA_IDLE;
         ad_d2 <= DATA_IDLE;
         ad_d3 <= DATA_IDLE;
      end else begin
         ad_d1 <= ad_in;
         ad_d2 <= ad_d1;
         ad_d3 <= ad_d2;
      end
   end

   // Falling edge of the filtered strobe marks one capture.
   // Taken from the next level, so the push lines up with ad_d3.
   logic ale_fall;                      // One-cycle capture pulse
   assign ale_fall = ale_q && !next_ale_q;

   // History stack, slot 0 is the current address
   logic [DATA_W-1:0] stack      [STACK_DEPTH];
   logic [DATA_W-1:0] next_stack [STACK_DEPTH];

   // Push on capture only; reads never touch the stack
   always_comb begin
      for (int i = 0; i < STACK_DEPTH; i++) begin
         next_stack[i] = stack[i];
      end
      if (ale_fall) begin                                  // RULE8
         next_stack[0] = ad_d3;                            // RULE1
         for (int i = 1; i < STACK_DEPTH; i++) begin       // RULE3
            next_stack[i] = stack[i-1];                    // RULE2
         end
         // The oldest entry falls off the end; no overflow flag is kept
      end
   end

   // The pins carry no reset pattern; all-zero slots are this block's choice
   always_ff @(posedge mclk or negedge rst_n_i) begin
      if (!rst_n_i) begin
         for (int i = 0; i < STACK_DEPTH; i++) begin
            stack[i] <= DATA_IDLE;
         end
      end else begin
         for (int i = 0; i < STACK_DEPTH; i++) begin
            stack[i] <= next_stack[i];
         end
      end
   end

   assign cur_addr = stack[0];

   // True when the latched address is one of the two history locations
   function automatic logic hist_hit(input logic [DATA_W-1:0] a);
      hist_hit = (a == ADDR_HIST_TWO) || (a == ADDR_HIST_OTHER);
   endfunction : hist_hit

   // Read data path: registered; other addresses leave the bus idle
   logic [DATA_W-1:0] next_ad_out;
   logic              next_ad_oe_n;
   // A read only answers while the latched address points at history
   always_comb begin
      next_ad_out  = DATA_IDLE;
      next_ad_oe_n = 1'b1;
      if (!cs_q && !rd_q && hist_hit(stack[0])) begin      // RULE4
         next_ad_oe_n = 1'b0;
         if (stack[0] == ADDR_HIST_TWO) begin
            next_ad_out = stack[SLOT_TWO];                 // RULE6
         end else begin
            next_ad_out = stack[SLOT_OTHER];
         end
      end
   end

   // Registered so the pins never show the slot mux settling.
   // The price is one more cycle before read data stands.
   always_ff @(posedge mclk or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ad_out  <= DATA_IDLE;
         ad_oe_n <= 1'b1;
      end else begin
         ad_out  <= next_ad_out;
         ad_oe_n <= next_ad_oe_n;
      end
   end

   // Checks, all held off until the released reset is high.
   // Each one watches state that the block itself drives.
   // A capture moves slot 0 down into slot 1 and slot 2 down into slot 3
   a_push_shift_order: assert property (@(posedge mclk) disable iff (!rst_n_i) // RULE2
      ale_fall |=> (stack[1] == $past(stack[0]) && stack[3] == $past(stack[2])))
      else $error("stack did not shift on capture");

   // The new top entry is the bus value aligned with the strobe
   a_capture_bus_value: assert property (@(posedge mclk) disable iff (!rst_n_i) // RULE1
      ale_fall |=> stack[0] == $past(ad_d3))
      else $error("captured address wrong");

   // No capture, no change at the ends of the stack
   a_stack_hold_idle: assert property (@(posedge mclk) disable iff (!rst_n_i) // RULE8
      !ale_fall |=> $stable(stack[0]) && $stable(stack[3]))
      else $error("stack changed without capture");

   // Nor in the middle slots, so a read cannot disturb them
   a_stack_hold_mid: assert property (@(posedge mclk) disable iff (!rst_n_i) // RULE8
      !ale_fall |=> $stable(stack[1]) && $stable(stack[2]))
      else $error("middle slots changed without capture");

   // The first location answers with the entry two captures back
   a_read_slot_two: assert property (@(posedge mclk) disable iff (!rst_n_i) // RULE6
      (!cs_q && !rd_q && stack[0] == ADDR_HIST_TWO && !ale_fall)
      |=> (!ad_oe_n && ad_out == $past(stack[2])))
      else $error("slot two read wrong");

   // The second location answers with the oldest entry
   a_read_slot_other: assert property (@(posedge mclk) disable iff (!rst_n_i) // RULE4
      (!cs_q && !rd_q && stack[0] == ADDR_HIST_OTHER && !ale_fall)
      |=> (!ad_oe_n && ad_out == $past(stack[3])))
      else $error("oldest slot read wrong");

   // Any other latched address leaves the bus undriven
   a_read_unmapped_idle: assert property (@(posedge mclk) disable iff (!rst_n_i) // RULE4
      !hist_hit(stack[0]) |=> ad_oe_n)
      else $error("bus driven for unmapped address");

   // Dropping select or read releases the bus one edge later
   a_read_release: assert property (@(posedge mclk) disable iff (!rst_n_i) // RULE4
      (cs_q || rd_q) |=> ad_oe_n)
      else $error("bus driven without select and read");

   // Data lines rest at the idle pattern while not driven
   a_oe_data_idle: assert property (@(posedge mclk) disable iff (!rst_n_i) // RULE4
      ad_oe_n |-> ad_out == DATA_IDLE)
      else $error("data not idle while released");

   // The third slot takes the second, so the former oldest is gone
   a_oldest_dropped: assert property (@(posedge mclk) disable iff (!rst_n_i) // RULE3
      ale_fall |=> (stack[2] == $past(stack[1]) && stack[3] == $past(stack[2])))
      else $error("oldest entry not replaced on capture");

endmodule : address_latch_recovery_stack
`default_nettype wire

// *** verification/host_model.sv ***
`default_nettype none
module host_model (
   // Clock and read path from the device
   input  wire logic       mclk,
   input  wire logic       ad_oe_n,
   input  wire logic [7:0] ad_out,
   // Bus pins driven by the host
   output logic            addr_strobe,
   output logic            chip_sel_n,
   output logic            rd_n,
   output logic [7:0]      ad_in
);
   timeunit 1ns;
   timeprecision 1ps;
   // Idle bus, strobes inactive
   initial begin
      addr_strobe = 1'b0;
      chip_sel_n = 1'b1;
      rd_n = 1'b1;
      ad_in = 8'h00;
   end
   // Strobe cycle; address held well around the fall for the synchronisers
   task automatic latch(input logic [7:0] a);
      @(posedge mclk) #1 ad_in = a;
      addr_strobe = 1'b1;
      repeat (4) @(posedge mclk);
      #1 addr_strobe = 1'b0;
      repeat (5) @(posedge mclk);
      #1 ad_in = ~a; // Released bus must not show a stale address
      repeat (3) @(posedge mclk);
   endtask : latch
   // Read cycle; selects held until the device drives, wait bounded
   task automatic rd(output logic [7:0] d, output logic ok);
      @(posedge mclk) #1 chip_sel_n = 1'b0;
      rd_n = 1'b0;
      repeat (10) if (ad_oe_n !== 1'b0) @(posedge mclk) #1;
      ok = (ad_oe_n === 1'b0);
      d = ad_out;
      rd_n = 1'b1;
      chip_sel_n = 1'b1;
      repeat (6) @(posedge mclk);
   endtask : rd
endmodule : host_model
`default_nettype wire

// *** verification/address_latch_recovery_stack_bench.sv ***
`default_nettype none
module address_latch_recovery_stack_bench;
   import addr_stack_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic              mclk = 1'b0;
   logic              reset_n = 1'b0;
   logic              addr_strobe, chip_sel_n, rd_n, ad_oe_n, ok;
   logic [DATA_W-1:0] ad_in, ad_out, cur_addr, d;
   int                n_mismatch = 0, cmp_count = 0, cyc = 0;
   // 200 MHz clock
   always #2.5 mclk = ~mclk;
   address_latch_recovery_stack DUT (.mclk(mclk), .reset_n(reset_n),
      .addr_strobe(addr_strobe), .chip_sel_n(chip_sel_n), .rd_n(rd_n),
      .ad_in(ad_in), .ad_out(ad_out), .ad_oe_n(ad_oe_n), .cur_addr(cur_addr));
   host_model HOST (.mclk(mclk), .ad_oe_n(ad_oe_n), .ad_out(ad_out),
      .addr_strobe(addr_strobe), .chip_sel_n(chip_sel_n), .rd_n(rd_n), .ad_in(ad_in));
   // Compare and count
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   // Single exit point
   task automatic end_sim();
      $display("Compared %0d, mismatched %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : end_sim
   // Hang guard; the whole run needs well under 1000 cycles
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 3000) begin
         n_mismatch++;
         end_sim();
      end
   end
   // Fill past four entries, read both locations, reread
   task automatic s_history();
      HOST.latch(8'h11);
      HOST.latch(8'h22);
      HOST.latch(8'h33);
      chk("cur_addr", cur_addr, 8'h33);
      HOST.latch(ADDR_HIST_TWO);
      HOST.rd(d, ok);
      chk("slot_two", d, 8'h22);
      chk("oe_slot_two", {7'h00, ok}, 8'h01);
      HOST.latch(ADDR_HIST_OTHER);
      HOST.rd(d, ok);
      chk("slot_other", d, 8'h22);
      HOST.rd(d, ok);
      chk("reread", d, 8'h22);
      chk("cur_after_read", cur_addr, ADDR_HIST_OTHER);
   endtask : s_history
   // Interrupted access, then recovery through the control address
   task automatic s_recover();
      HOST.latch(8'h5c);
      // The latch of the control address pushes the lost address down
      HOST.latch(ADDR_CTRL_A);
      HOST.latch(ADDR_HIST_TWO);
      HOST.rd(d, ok);
      chk("lost_addr", d, 8'h5c);
      HOST.latch(d);
      chk("reissued", cur_addr, 8'h5c);
   endtask : s_recover
   // Read of a place outside the history leaves the bus alone
   task automatic s_refuse();
      HOST.latch(ADDR_CTRL_A);
      HOST.rd(d, ok);
      chk("oe_refused", {7'h00, ok}, 8'h00);
      chk("idle_data", d, DATA_IDLE);
   endtask : s_refuse
   // Mid-run reset clears the history; one push then shows a cleared oldest slot
   task automatic s_reset();
      @(posedge mclk) #1 reset_n = 1'b0;
      repeat (3) @(posedge mclk);
      chk("cur_in_reset", cur_addr, DATA_IDLE);
      #1 reset_n = 1'b1;
      repeat (3) @(posedge mclk);
      HOST.latch(ADDR_HIST_OTHER);
      HOST.rd(d, ok);
      chk("slot_other_reset", d, DATA_IDLE);
      chk("oe_after_reset", {7'h00, ok}, 8'h01);
   endtask : s_reset
   initial begin
      repeat (20) @(posedge mclk);
      #1 reset_n = 1'b1;
      repeat (3) @(posedge mclk);
      s_history();
      s_recover();
      s_refuse();
      s_reset();
      end_sim();
   end
endmodule : address_latch_recovery_stack_bench
`default_nettype wire
